// *** usr_pkg.sv ***
// Purpose: shared constants and types for the sync receive/command block
// Assumes: 8-bit host bus, both address bits decode data, control, interrupt status and mask
// Notes:   bit layouts follow the usual serial-controller arrangement
package usr_pkg;

    // mode word fields
    localparam int MODE_SYNC_LO   = 0;  // baud field 00 means synchronous
    localparam int MODE_LEN_LO    = 2;  // character length, 2 bits
    localparam int MODE_PEN_BIT   = 4;  // parity enable
    localparam int MODE_EVEN_BIT  = 5;  // even parity
    localparam int MODE_EXT_BIT   = 6;  // external sync detect
    localparam int MODE_SGL_BIT   = 7;  // single sync character

    // command word fields
    localparam int CMD_TXEN_BIT   = 0;  // transmitter enable
    localparam int CMD_DTR_BIT    = 1;  // terminal ready output
    localparam int CMD_RXEN_BIT   = 2;  // receiver enable
    localparam int CMD_ERR_BIT    = 4;  // error reset
    localparam int CMD_RTS_BIT    = 5;  // request to send output
    localparam int CMD_RST_BIT    = 6;  // internal reset
    localparam int CMD_HUNT_BIT   = 7;  // enter hunt

    // status fields
    localparam int ST_TRANSMITTER_READY_BIT   = 0;
    localparam int ST_RECEIVER_READY_BIT   = 1;
    localparam int ST_TXE_BIT     = 2;
    localparam int ST_PE_BIT      = 3;
    localparam int ST_OE_BIT      = 4;
    localparam int ST_FE_BIT      = 5;
    localparam int ST_SYN_BIT     = 6;
    localparam int ST_DSR_BIT     = 7;

    // register offsets on the plain port
    localparam logic [1:0] ADDR_DATA = 2'h0;  // data byte
    localparam logic [1:0] ADDR_CTRL = 2'h1;  // mode/sync/command, status
    localparam logic [1:0] ADDR_IST  = 2'h2;  // interrupt status, w1c
    localparam logic [1:0] ADDR_IMSK = 2'h3;  // interrupt mask

    // interrupt status bit positions
    localparam int IRQ_RX_BIT     = 0;  // character received
    localparam int IRQ_ERR_BIT    = 1;  // parity or overrun
    localparam int IRQ_SYN_BIT    = 2;  // sync found
    localparam int IRQ_W          = 3;

    // reset values and timing
    localparam logic [7:0] CMD_RESET  = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam int STATUS_LAG_MAX = 16;  // clock periods, base variant
    localparam int STATUS_LAG     = 2;   // cycles this design actually takes

    // control write sequencing
    typedef enum logic [1:0] {
        USR_SEQ_MODE, USR_SEQ_SYNC1, USR_SEQ_SYNC2, USR_SEQ_CMD
    } usr_seq_t;

    // register bus request
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } usr_bus_t;

    // modem side pin group
    typedef struct packed {
        logic dtr_n;
        logic rts_n;
    } usr_modem_t;

endpackage : usr_pkg

// *** usr_rx_shift.sv ***
// Purpose: serial receive engine with hunt, parity and character assembly
// Assumes: serial inputs already synchronised; rise is one clock pulse
// Notes:   bits sample on the rising receive clock edge
`timescale 1ns/1ps
module usr_rx_shift (
    // clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    // configuration
    input  wire logic [7:0] mode_in,
    input  wire logic [7:0] sync1_in,
    input  wire logic [7:0] sync2_in,
    input  wire logic       hunt_req_in,
    // serial side
    input  wire logic       bit_rise_in,
    input  wire logic       rxd_in,
    input  wire logic       ext_sync_in,
    // results
    output logic            done_out,
    output logic [7:0]      char_out,
    output logic            perr_out,
    output logic            sync_hit_out,
    output logic            hunting_out
);
    import usr_pkg::*;

    logic [7:0] shift_q;      // received bits, newest at top
    logic [3:0] cnt_q;        // bits taken for current character
    logic       hunt_q;       // searching for sync
    logic       second_q;     // checking the second sync character
    logic [3:0] len;          // data bits per character
    logic [3:0] total;        // data plus parity
    logic [7:0] nxt;          // shift register after this bit
    logic [7:0] aligned;      // character shifted down to bit 0
    logic       par_calc;     // xor of data bits
    logic       pen;

    assign pen   = mode_in[MODE_PEN_BIT];
    assign len   = 4'd5 + {2'b00, mode_in[MODE_LEN_LO +: 2]};
    assign total = len + {3'b000, pen};
    assign nxt   = {rxd_in, shift_q[7:1]};

    // justify data to the low bits; unused high bits read zero
    always_comb begin
        aligned = nxt >> (4'd8 - len);
        if (pen && cnt_q + 4'd1 == total) begin
            aligned = shift_q >> (4'd8 - len);
        end
        par_calc = ^aligned;
    end

    ////////////////////////////////////////////////////////////////////////
    // bit assembly and hunt
    always_ff @(posedge sys_clk_in) begin
        done_out     <= 1'b0;
        perr_out     <= 1'b0;
        sync_hit_out <= 1'b0;
        if (rst_in) begin
            shift_q  <= 8'h00;
            cnt_q    <= 4'd0;
            hunt_q   <= 1'b1;
            second_q <= 1'b0;
            char_out <= 8'h00;
        end else if (hunt_req_in) begin
            hunt_q   <= 1'b1;
            second_q <= 1'b0;
            cnt_q    <= 4'd0;
        end else if (hunt_q && mode_in[MODE_EXT_BIT]) begin
            if (ext_sync_in) begin
                hunt_q       <= 1'b0;
                cnt_q        <= 4'd0;
                sync_hit_out <= 1'b1;
            end
        end else if (bit_rise_in) begin
            shift_q <= nxt;
            if (hunt_q && !second_q) begin
                if (aligned == sync1_in) begin
                    cnt_q <= 4'd0;
                    if (mode_in[MODE_SGL_BIT]) begin
                        hunt_q       <= 1'b0;
                        sync_hit_out <= 1'b1;
                    end else begin
                        second_q <= 1'b1;
                    end
                end
            end else if (cnt_q + 4'd1 == total) begin
                cnt_q <= 4'd0;
                if (hunt_q) begin
                    second_q <= 1'b0;
                    if (aligned == sync2_in) begin
                        hunt_q       <= 1'b0;
                        sync_hit_out <= 1'b1;
                    end
                end else begin
                    char_out <= aligned;
                    done_out <= 1'b1;
                    perr_out <= pen &&
                        (rxd_in != (par_calc ^ !mode_in[MODE_EVEN_BIT]));
                end
            end else begin
                cnt_q <= cnt_q + 4'd1;
            end
        end
    end

    assign hunting_out = hunt_q;

endmodule : usr_rx_shift

// *** usr_sync_rx.sv ***
// Purpose: host-facing control, status and error flags for sync receive
// Assumes: serial pins and receive clock arrive from outside this domain
// Notes:   asynchronous framing is never produced in this build
`timescale 1ns/1ps

// What this block does
// - external sync pin level takes character sync
// - parity and overrun checked as asynchronous
// - framing flag never set in synchronous format
// - hunt bit in command restarts sync search
// - short characters read with zero upper bits
// - later control writes load command register
// - after reset next control write is mode
// - command drives enables, error reset, modem
// - control read returns status byte
// - status DSR bit mirrors the DSR pin
// - status update lag within sixteen clocks
// - parity flag sticky until error reset
// - overrun flag, old character overwritten
// - framing flag only for asynchronous stop
// - ready status bit means buffer empty
// - hunt compares each bit, second sync
// - sync detect raised, cleared on status read
// - receive ready cleared by data read
module usr_sync_rx (
    // clock and reset
    input  wire logic            sys_clk_in,
    input  wire logic            rst_in,
    // register port
    input  wire usr_pkg::usr_bus_t bus_in,
    output logic [7:0]           rdata_out,
    // serial side
    input  wire logic            receive_clock_in,
    input  wire logic            rxd_in,
    input  wire logic            sync_detect_pin_in,
    input  wire logic            dsr_n_in,
    input  wire logic            cts_n_in,
    // pins driven
    output logic                 sync_detect_pin_out,
    output logic                 sync_detect_pin_oe_out,
    output logic                 receiver_ready_out,
    output logic                 transmitter_ready_out,
    output usr_pkg::usr_modem_t  modem_out,
    output logic                 irq_out
);
    import usr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state
    usr_seq_t   seq_q;         // which control word comes next
    logic [7:0] mode_q;        // mode word
    logic [7:0] sync1_q;       // first sync character
    logic [7:0] sync2_q;       // second sync character
    logic [7:0] cmd_q;         // command register
    logic [7:0] data_q;        // received character held for host
    logic       receiver_ready_q;       // character waiting
    logic       txbuf_empty_q; // transmit holding buffer empty
    logic       pe_q;          // parity_error_flag
    logic       oe_q;          // overrun flag
    logic       fe_q;          // framing_flag
    logic       syn_q;         // sync found, cleared on status read
    logic [7:0] status_q;      // status as seen by the host, one cycle late
    logic [7:0] rdata_q;
    logic [IRQ_W-1:0] ist_q;   // interrupt status
    logic [IRQ_W-1:0] imsk_q;  // interrupt mask
    logic       hunt_pulse_q;  // one-cycle hunt request
    logic       rst_int_q;     // internal reset from command

    // two-stage synchronisers for outside inputs
    logic [1:0] rxc_s_q, rxd_s_q, ext_s_q, dsr_s_q, cts_s_q;
    logic       rxc_prev_q;    // last synchronised receive clock

    ////////////////////////////////////////////////////////////////////////
    // decoding
    logic       wr_ctrl, wr_data, rd_ctrl, rd_data, wr_ist, wr_imsk;
    logic       is_sync;
    logic       rise;
    logic       core_rst;
    logic       done, perr, sync_hit, hunting;
    logic [7:0] rx_char;
    logic [7:0] status_now;
    logic [IRQ_W-1:0] events;
    logic       err_reset;

    assign wr_ctrl  = bus_in.wr && bus_in.addr == ADDR_CTRL;
    assign wr_data  = bus_in.wr && bus_in.addr == ADDR_DATA;
    assign rd_ctrl  = bus_in.rd && bus_in.addr == ADDR_CTRL;
    assign rd_data  = bus_in.rd && bus_in.addr == ADDR_DATA;
    assign wr_ist   = bus_in.wr && bus_in.addr == ADDR_IST;
    assign wr_imsk  = bus_in.wr && bus_in.addr == ADDR_IMSK;
    assign is_sync  = mode_q[MODE_SYNC_LO +: 2] == 2'b00;
    // receive clock edge found from the second synchroniser stage only
    assign rise     = rxc_s_q[1] && !rxc_prev_q;
    assign core_rst = rst_in || rst_int_q;
    assign err_reset = wr_ctrl && seq_q == USR_SEQ_CMD &&
                       bus_in.wdata[CMD_ERR_BIT];

    ////////////////////////////////////////////////////////////////////////
    // synchronisers
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rxc_s_q    <= 2'b00;
            rxd_s_q    <= 2'b11;
            ext_s_q    <= 2'b00;
            dsr_s_q    <= 2'b11;
            cts_s_q    <= 2'b11;
            rxc_prev_q <= 1'b0;
        end else begin
            rxc_s_q    <= {rxc_s_q[0], receive_clock_in};
            rxd_s_q    <= {rxd_s_q[0], rxd_in};
            ext_s_q    <= {ext_s_q[0], sync_detect_pin_in};
            dsr_s_q    <= {dsr_s_q[0], dsr_n_in};
            cts_s_q    <= {cts_s_q[0], cts_n_in};
            rxc_prev_q <= rxc_s_q[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive engine
    usr_rx_shift u_shift (
        .sys_clk_in   (sys_clk_in),
        .rst_in       (core_rst),
        .mode_in      (mode_q),
        .sync1_in     (sync1_q),
        .sync2_in     (sync2_q),
        .hunt_req_in  (hunt_pulse_q),
        .bit_rise_in  (rise && is_sync),
        .rxd_in       (rxd_s_q[1]),
        .ext_sync_in  (ext_s_q[1]),
        .done_out     (done),
        .char_out     (rx_char),
        .perr_out     (perr),
        .sync_hit_out (sync_hit),
        .hunting_out  (hunting)
    );

    ////////////////////////////////////////////////////////////////////////
    // control write sequencing
    always_ff @(posedge sys_clk_in) begin
        hunt_pulse_q <= 1'b0;
        rst_int_q    <= 1'b0;
        if (rst_in || rst_int_q) begin
            seq_q  <= USR_SEQ_MODE;
            cmd_q  <= CMD_RESET;
            if (rst_in) begin
                mode_q  <= MODE_RESET;
                sync1_q <= 8'h00;
                sync2_q <= 8'h00;
            end
        end else if (wr_ctrl) begin
            unique case (seq_q)
                USR_SEQ_MODE: begin
                    mode_q <= bus_in.wdata;
                    seq_q  <= (bus_in.wdata[MODE_SYNC_LO +: 2] == 2'b00)
                              ? USR_SEQ_SYNC1 : USR_SEQ_CMD;
                end
                USR_SEQ_SYNC1: begin
                    sync1_q <= bus_in.wdata;
                    seq_q   <= mode_q[MODE_SGL_BIT] ? USR_SEQ_CMD
                                                    : USR_SEQ_SYNC2;
                end
                USR_SEQ_SYNC2: begin
                    sync2_q <= bus_in.wdata;
                    seq_q   <= USR_SEQ_CMD;
                end
                USR_SEQ_CMD: begin
                    cmd_q        <= bus_in.wdata;
                    hunt_pulse_q <= bus_in.wdata[CMD_HUNT_BIT];
                    rst_int_q    <= bus_in.wdata[CMD_RST_BIT];
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive data and error flags; sets win over clears
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            data_q  <= 8'h00;
            receiver_ready_q <= 1'b0;
            pe_q    <= 1'b0;
            oe_q    <= 1'b0;
            fe_q    <= 1'b0;
            syn_q   <= 1'b0;
        end else begin
            if (done && cmd_q[CMD_RXEN_BIT]) begin
                data_q  <= rx_char;
                receiver_ready_q <= 1'b1;
            end else if (rd_data) begin
                receiver_ready_q <= 1'b0;
            end
            if (done && cmd_q[CMD_RXEN_BIT] && receiver_ready_q && !rd_data) begin
                oe_q <= 1'b1;
            end else if (err_reset) begin
                oe_q <= 1'b0;
            end
            if (perr && !hunting) begin
                pe_q <= 1'b1;
            end else if (err_reset) begin
                pe_q <= 1'b0;
            end
            // no stop bit in sync format
            if (err_reset) begin
                fe_q <= 1'b0;
            end
            // set on sync, status read clears
            if (sync_hit) begin
                syn_q <= 1'b1;
            end else if (rd_ctrl) begin
                syn_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit buffer empty tracking: a data write fills it; the sender
    // is outside this block, so the buffer drains while transmit is on and CTS is low
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            txbuf_empty_q <= 1'b1;
        end else if (wr_data) begin
            txbuf_empty_q <= 1'b0;
        end else if (cmd_q[CMD_TXEN_BIT] && !cts_s_q[1]) begin
            txbuf_empty_q <= 1'b1;
        end
    end

    assign status_now = {!dsr_s_q[1], syn_q, fe_q, oe_q, pe_q,
                         txbuf_empty_q, receiver_ready_q, txbuf_empty_q};

    ////////////////////////////////////////////////////////////////////////
    // status snapshot and read data, read data one cycle after strobe
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            status_q <= 8'h00;
            rdata_q  <= 8'h00;
        end else begin
            status_q <= status_now;
            unique case (bus_in.addr)
                ADDR_DATA: rdata_q <= data_q;
                ADDR_CTRL: rdata_q <= status_q;
                ADDR_IST:  rdata_q <= {5'h00, ist_q};
                ADDR_IMSK: rdata_q <= {5'h00, imsk_q};
            endcase
            if (!bus_in.rd) begin
                rdata_q <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, write one to clear, set wins
    assign events = {sync_hit, (perr && !hunting) ||
                     (done && receiver_ready_q && cmd_q[CMD_RXEN_BIT] && !rd_data),
                     done && cmd_q[CMD_RXEN_BIT]};

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ist_q  <= '0;
            imsk_q <= '0;
            irq_out <= 1'b0;
        end else begin
            ist_q <= events |
                     (ist_q & ~(wr_ist ? bus_in.wdata[IRQ_W-1:0] : '0));
            if (wr_imsk) begin
                imsk_q <= bus_in.wdata[IRQ_W-1:0];
            end
            irq_out <= |(ist_q & imsk_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin outputs, all registered
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sync_detect_pin_out    <= 1'b0;
            sync_detect_pin_oe_out <= 1'b0;
            receiver_ready_out     <= 1'b0;
            transmitter_ready_out  <= 1'b0;
            modem_out              <= '1;
        end else begin
            // drive only in internal sync mode
            sync_detect_pin_out    <= syn_q;
            sync_detect_pin_oe_out <= is_sync && !mode_q[MODE_EXT_BIT];
            receiver_ready_out     <= receiver_ready_q;
            transmitter_ready_out  <= txbuf_empty_q && !cts_s_q[1] &&
                                      cmd_q[CMD_TXEN_BIT];
            modem_out.dtr_n        <= !cmd_q[CMD_DTR_BIT];
            modem_out.rts_n        <= !cmd_q[CMD_RTS_BIT];
        end
    end

    assign rdata_out = rdata_q;

endmodule : usr_sync_rx

// *** usr_sync_rx_assertions.sv ***
// Purpose: port-level checks for the sync receive block
// Assumes: host strobes are one-cycle pulses
// Notes:   sees only the top module's ports
`timescale 1ns/1ps
module usr_sync_rx_assertions
    import usr_pkg::*;
(
    // clock and reset
    input wire logic                sys_clk_in,
    input wire logic                rst_in,
    // host port
    input wire usr_pkg::usr_bus_t   bus_in,
    input wire logic [7:0]          rdata_out,
    // pins
    input wire logic                dsr_n_in,
    input wire logic                cts_n_in,
    input wire logic                sync_detect_pin_out,
    input wire logic                sync_detect_pin_oe_out,
    input wire logic                receiver_ready_out,
    input wire logic                transmitter_ready_out,
    input wire usr_pkg::usr_modem_t modem_out,
    input wire logic                irq_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // decoded host requests
    wire rd_ctrl = bus_in.rd && (bus_in.addr == ADDR_CTRL);
    wire rd_data = bus_in.rd && (bus_in.addr == ADDR_DATA);
    wire msk_off = bus_in.wr && (bus_in.addr == ADDR_IMSK)
                   && (bus_in.wdata == 8'h00);
    // pins held long enough to cross the synchroniser
    sequence dsr_idle; dsr_n_in[*8]; endsequence
    sequence cts_off; cts_n_in[*8]; endsequence
    ////////////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (
        !bus_in.rd |=> rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    a_frame_never: assert property (
        rd_ctrl |=> rdata_out[ST_FE_BIT] == 1'b0)
        else $error("framing flag seen in sync format");
    a_dsr_status: assert property (
        dsr_idle ##0 rd_ctrl |=> !rdata_out[ST_DSR_BIT])
        else $error("status modem bit does not follow pin");
    a_transmitter_ready_cts: assert property (
        cts_off |-> !transmitter_ready_out)
        else $error("transmit ready pin high without clear");
    a_receiver_ready_clear: assert property (
        rd_data |-> ##[1:3] !receiver_ready_out)
        else $error("receive ready kept after data read");
    a_sync_clear: assert property (
        rd_ctrl && sync_detect_pin_oe_out |-> ##[1:3] !sync_detect_pin_out)
        else $error("sync pin kept after status read");
    a_irq_mask: assert property (
        msk_off |-> ##2 !irq_out)
        else $error("interrupt high with mask cleared");
    a_reset_vals: assert property (
        $fell(rst_in) |-> modem_out == 2'b11 && !irq_out
                          && !sync_detect_pin_oe_out)
        else $error("outputs not idle after reset");
endmodule : usr_sync_rx_assertions

bind usr_sync_rx usr_sync_rx_assertions i_usr_sync_rx_assertions (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_in(bus_in),
    .rdata_out(rdata_out), .dsr_n_in(dsr_n_in), .cts_n_in(cts_n_in),
    .sync_detect_pin_out(sync_detect_pin_out),
    .sync_detect_pin_oe_out(sync_detect_pin_oe_out),
    .receiver_ready_out(receiver_ready_out),
    .transmitter_ready_out(transmitter_ready_out),
    .modem_out(modem_out), .irq_out(irq_out));

// *** usr_ser_src.sv ***
// Purpose: far-end serial transmitter feeding the receive pins
// Assumes: 160 ns link clock, runs only inside a frame
// Notes:   data changes while the clock is low, lsb first
`timescale 1ns/1ps
module usr_ser_src (
    // serial pins toward the block
    output logic rclk_out,
    output logic rxd_out
);
    // clock rests low between frames
    initial begin
        rclk_out = 1'b0;
        rxd_out  = 1'b0;
    end
    // shift n bits; the released line shows the inverse of the last bit
    task automatic send(input logic [8:0] bits, input int n);
        #5;  // stay clear of system clock edges
        for (int i = 0; i < n; i++) begin
            rxd_out = bits[i];
            #80 rclk_out = 1'b1;
            #80 rclk_out = 1'b0;
        end
        rxd_out = ~rxd_out;
    endtask : send
endmodule : usr_ser_src

// *** usr_sync_rx_tb_top.sv ***
// Purpose: self-checking bench for the sync receive block
// Assumes: 50 MHz system clock, link clock from the partner
// Notes:   flags read through the control/status offset
`timescale 1ns/1ps
module usr_sync_rx_tb_top;
    import usr_pkg::*;
    logic       sys_clk_in = 1'b0;
    logic       rst_in     = 1'b1;
    usr_bus_t   bus_in     = '0;
    logic       sync_pin   = 1'b0;  // external sync level
    logic       dsr_n      = 1'b1;
    logic       cts_n      = 1'b0;
    logic [7:0] rdata, v;
    logic       rclk, rxd, syn, syn_oe, rx_rdy, tx_rdy, irq;
    usr_modem_t modem;
    int         n_errors     = 0;
    int         total_checks = 0;
    always #10 sys_clk_in = ~sys_clk_in;
    usr_ser_src i_usr_ser_src (.rclk_out(rclk), .rxd_out(rxd));
    usr_sync_rx i_usr_sync_rx (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_in(bus_in),
        .rdata_out(rdata), .receive_clock_in(rclk), .rxd_in(rxd),
        .sync_detect_pin_in(sync_pin), .dsr_n_in(dsr_n), .cts_n_in(cts_n),
        .sync_detect_pin_out(syn), .sync_detect_pin_oe_out(syn_oe),
        .receiver_ready_out(rx_rdy), .transmitter_ready_out(tx_rdy),
        .modem_out(modem), .irq_out(irq));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_in);
        bus_in <= '0;
    endtask : bus_wr
    // read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_in);
        bus_in <= '0;
        #1 d = rdata;
    endtask : bus_rd
    // bounded wait for a finished character
    task automatic wait_rx;
        for (int i = 0; i < 100 && !rx_rdy; i++) @(posedge sys_clk_in);
        chk("rx ready", 8'(rx_rdy), 8'h01);
    endtask : wait_rx
    task automatic t_setup;
        chk("modem idle", 8'(modem), 8'h03);
        bus_wr(ADDR_IMSK, 8'h07);
        bus_wr(ADDR_CTRL, 8'hBC);  // 8 bits, even parity, one sync
        bus_wr(ADDR_CTRL, 8'h16);
        bus_wr(ADDR_CTRL, 8'hB7);  // enables, error reset, hunt
        repeat (2) @(posedge sys_clk_in);
        chk("modem on", 8'(modem), 8'h00);
        chk("sync oe", 8'(syn_oe), 8'h01);
        i_usr_ser_src.send(9'h016, 8);
        repeat (8) @(posedge sys_clk_in);
        chk("sync pin", 8'(syn), 8'h01);
        chk("sync irq", 8'(irq), 8'h01);
        bus_rd(ADDR_CTRL, v);
        chk("sync status", v & 8'h40, 8'h40);
        repeat (3) @(posedge sys_clk_in);
        chk("sync cleared", 8'(syn), 8'h00);
        $display("test setup done");
    endtask : t_setup
    task automatic t_char;
        bus_wr(ADDR_IST, 8'h07);
        i_usr_ser_src.send(9'h0A5, 9);
        wait_rx();
        bus_rd(ADDR_CTRL, v);
        chk("status clean", v & 8'h3A, 8'h02);
        bus_rd(ADDR_DATA, v);
        chk("char", v, 8'hA5);
        repeat (3) @(posedge sys_clk_in);
        chk("rx cleared", 8'(rx_rdy), 8'h00);
        chk("irq rx", 8'(irq), 8'h01);
        bus_wr(ADDR_IMSK, 8'h00);
        bus_wr(ADDR_IST, 8'h07);
        bus_wr(ADDR_IMSK, 8'h07);
        repeat (2) @(posedge sys_clk_in);
        chk("irq cleared", 8'(irq), 8'h00);
        $display("test char done");
    endtask : t_char
    // bad parity, then good char, then error reset
    task automatic t_parity;
        i_usr_ser_src.send(9'h1A5, 9);
        wait_rx();
        bus_rd(ADDR_DATA, v);
        i_usr_ser_src.send(9'h0A5, 9);
        wait_rx();
        bus_rd(ADDR_DATA, v);
        chk("char after pe", v, 8'hA5);
        bus_rd(ADDR_CTRL, v);
        chk("pe sticky", v & 8'h28, 8'h08);
        bus_wr(ADDR_CTRL, 8'h17);
        bus_rd(ADDR_CTRL, v);
        chk("pe cleared", v & 8'h08, 8'h00);
        chk("modem rts off", 8'(modem), 8'h01);
        $display("test parity done");
    endtask : t_parity
    task automatic t_overrun;
        i_usr_ser_src.send(9'h03C, 9);
        i_usr_ser_src.send(9'h0C3, 9);
        wait_rx();
        bus_rd(ADDR_CTRL, v);
        chk("oe set", v & 8'h10, 8'h10);
        bus_rd(ADDR_DATA, v);
        chk("char kept", v, 8'hC3);
        bus_wr(ADDR_CTRL, 8'h17);
        bus_rd(ADDR_CTRL, v);
        chk("oe cleared", v & 8'h10, 8'h00);
        $display("test overrun done");
    endtask : t_overrun
    task automatic t_pins;
        @(posedge sys_clk_in);
        dsr_n <= 1'b0;
        cts_n <= 1'b1;
        repeat (16) @(posedge sys_clk_in);
        bus_rd(ADDR_CTRL, v);
        chk("dsr and empty", v & 8'h81, 8'h81);
        chk("tx pin held", 8'(tx_rdy), 8'h00);
        @(posedge sys_clk_in);
        dsr_n <= 1'b1;
        cts_n <= 1'b0;
        repeat (16) @(posedge sys_clk_in);
        chk("tx pin on", 8'(tx_rdy), 8'h01);
        $display("test pins done");
    endtask : t_pins
    // internal reset, external sync, five-bit characters
    task automatic t_short;
        bus_wr(ADDR_CTRL, 8'h40);
        bus_wr(ADDR_CTRL, 8'hC0);
        bus_wr(ADDR_CTRL, 8'h16);
        bus_wr(ADDR_CTRL, 8'h94);
        repeat (2) @(posedge sys_clk_in);
        chk("oe ext mode", 8'(syn_oe), 8'h00);
        sync_pin <= 1'b1;
        repeat (10) @(posedge sys_clk_in);
        sync_pin <= 1'b0;
        i_usr_ser_src.send(9'h01B, 5);
        wait_rx();
        bus_rd(ADDR_DATA, v);
        chk("short char", v, 8'h1B);
        $display("test short done");
    endtask : t_short
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    // watchdog well past the expected run
    initial begin
        #200_000;
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        t_setup();
        t_char();
        t_parity();
        t_overrun();
        t_pins();
        t_short();
        end_sim();
    end
endmodule : usr_sync_rx_tb_top
